// >>> hw/acd_cmd_decode.sv
// Combinational command decoder: class, parameter usage, unit/head usage.
// Assumes code and feature are stable while the caller samples outputs.
`timescale 1ns/1ns
`include "acd_regs.svh"
module acd_cmd_decode
  import acd_pkg::*;
(
  input  wire logic [7:0] code_i,    // Command code
  input  wire logic [7:0] feature_i, // Feature parameter
  output logic            known_o,   // Code recognised
  output logic [1:0]      cls_o,     // Acceptance class
  output logic [4:0]      use_o,     // Feature, count, number, cylinder, lba
  output acd_uh_t         uh_o       // Unit/head usage
);

  localparam logic Y = 1'h1;
  localparam logic N = 1'h0;

  // Packs one table row
  function automatic logic [8:0] row(input logic [1:0] c, input logic f,
    input logic s, input logic n, input logic y, input logic l);
    row = {Y, c, f, s, n, y, l, N};
  endfunction

  logic [8:0] r;
  acd_uh_t    uh;

  // Table lookup on the code, feature qualifying the key command
  always_comb
  begin
    r  = 9'h000;
    uh = UH_NONE;
    case (acd_cmd_t'(code_i))
      CMD_CHKPWR_A, CMD_CHKPWR_B, CMD_DIAG, CMD_FLUSH, CMD_IDENTIFY,
      CMD_IDLEIMM_A, CMD_IDLEIMM_B, CMD_NOP, CMD_RD_BUF, CMD_REQ_SENSE,
      CMD_SEC_DIS, CMD_SEC_PREP, CMD_SEC_ERASE, CMD_SEC_FREEZE,
      CMD_SEC_SET, CMD_SEC_UNLOCK, CMD_SLEEP_A, CMD_SLEEP_B, CMD_STBY_A,
      CMD_STBY_B, CMD_STBYIMM_A, CMD_STBYIMM_B:
      begin
        r  = row(`ACD_CLS_1, N, N, N, N, N);
        uh = UH_DRIVE;
      end
      CMD_WR_BUF:
      begin
        r  = row(`ACD_CLS_2, N, N, N, N, N);
        uh = UH_DRIVE;
      end
      CMD_IDLE_A, CMD_IDLE_B, CMD_SET_MULT:
      begin
        r  = row(`ACD_CLS_1, N, Y, N, N, N);
        uh = UH_DRIVE;
      end
      CMD_SET_FEAT:
      begin
        r  = row(`ACD_CLS_1, Y, N, N, N, N);
        uh = UH_DRIVE;
      end
      CMD_INIT:
      begin
        r  = row(`ACD_CLS_1, N, Y, N, N, N);
        uh = UH_FULL;
      end
      CMD_ERASE, CMD_RD_DMA, CMD_RD_MULT, CMD_READ_A, CMD_READ_B,
      CMD_VERIFY_A, CMD_VERIFY_B, CMD_TRANSLATE:
      begin
        r  = row(`ACD_CLS_1, N, Y, Y, Y, Y);
        uh = UH_FULL;
      end
      CMD_RDLONG_A, CMD_RDLONG_B:
      begin
        r  = row(`ACD_CLS_1, N, N, Y, Y, Y);
        uh = UH_FULL;
      end
      CMD_FORMAT:
      begin
        r  = row(`ACD_CLS_2, N, Y, N, Y, Y);
        uh = UH_FULL;
      end
      CMD_WR_DMA, CMD_WRITE_A, CMD_WRITE_B, CMD_WRITE_NE:
      begin
        r  = row(`ACD_CLS_2, N, Y, Y, Y, Y);
        uh = UH_FULL;
      end
      CMD_WRLONG_A, CMD_WRLONG_B:
      begin
        r  = row(`ACD_CLS_2, N, N, Y, Y, Y);
        uh = UH_FULL;
      end
      CMD_WR_MULT, CMD_WR_MULT_NE, CMD_WR_VERIFY:
      begin
        r  = row(`ACD_CLS_3, N, Y, Y, Y, Y);
        uh = UH_FULL;
      end
      CMD_KEY:
      begin
        uh = UH_FULL;
        if (feature_i <= `ACD_KEY_FEAT_MAX || feature_i == `ACD_KEY_FEAT_RD)
          r = row(`ACD_CLS_1, Y, Y, Y, Y, N);
        else if (feature_i == `ACD_KEY_FEAT_CHG)
          r = row(`ACD_CLS_2, Y, Y, Y, Y, N);
      end
      default:
      begin
        if (code_i[7:4] == `ACD_CMD_RECAL_HI)
        begin
          r  = row(`ACD_CLS_1, N, N, N, N, N);
          uh = UH_DRIVE;
        end
        else if (code_i[7:4] == `ACD_CMD_SEEK_HI)
        begin
          r  = row(`ACD_CLS_1, N, N, Y, Y, Y);
          uh = UH_FULL;
        end
      end
    endcase
  end

  // Unpacked row fields
  assign known_o = r[8];
  assign cls_o   = r[7:6];
  assign use_o   = r[5:1];
  assign uh_o    = known_o ? uh : UH_NONE;

endmodule

// >>> hw/acd_ctrl.sv
// Task-file control block: device control, drive address readback,
// interrupt pending and masking, command capture and decode.
// Assumes host strobes synchronous to CLOCK_I, at most one per cycle.
`timescale 1ns/1ns
`include "acd_regs.svh"
module acd_ctrl
  import acd_pkg::*;
(
  input  wire logic       CLOCK_I,        // Host clock, 125 MHz
  input  wire logic       RST_B_I,        // Hardware reset, active low
  input  wire logic [3:0] HOST_ADDR_I,    // Task-file offset
  input  wire logic       HOST_WR_I,      // Write strobe
  input  wire logic       HOST_RD_I,      // Read strobe
  input  wire logic [7:0] HOST_WDATA_I,   // Write data
  output logic      [7:0] HOST_RDATA_O,   // Read data, next cycle
  input  wire logic       BUSY_FLAG_I,    // Device busy flag
  input  wire logic       MEDIA_WRITE_I,  // Media write in progress
  input  wire logic [7:0] STATUS_I,       // Status byte to return
  input  wire logic       UNIT_ID_I,      // This card's unit number
  input  wire logic       EVT_DONE_I,     // Command completion pulse
  input  wire logic       EVT_DRQ_I,      // Data request pulse
  output logic            SOFT_RESET_O,   // Controller soft reset level
  output logic            IRQ_O,          // Interrupt request
  output logic            CFG_INT_O,      // Interrupt flag for config status
  output logic            CMD_STROBE_O,   // Accepted known command pulse
  output logic            CMD_ABORT_O,    // Unknown command abort pulse
  output logic      [7:0] CMD_CODE_O,     // Captured command code
  output logic      [1:0] CMD_CLASS_O,    // Acceptance class
  output logic      [4:0] CMD_USE_O,      // Feature, count, number, cyl, lba
  output acd_uh_t         CMD_UH_MODE_O,  // Unit/head usage
  output logic            CMD_UNIT_O,     // Selected unit
  output logic      [3:0] CMD_HEAD_O      // Head bits, zero if unused
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta_q;
  logic rst_b_q;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge CLOCK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      rst_meta_q <= 1'h0;
      rst_b_q    <= 1'h0;
    end
    else
    begin
      rst_meta_q <= 1'h1;
      rst_b_q    <= rst_meta_q;
    end
  end

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic wr_ctrl;
  logic wr_cmd;
  logic wr_feat;
  logic wr_dh;
  logic rd_stat;
  logic rd_alt;
  logic rd_addr;
  logic cmd_take;
  logic srst_q;

  // Strobe qualification per offset
  assign wr_ctrl  = HOST_WR_I & (HOST_ADDR_I == `ACD_OFS_DEV_CTRL);
  assign wr_cmd   = HOST_WR_I & (HOST_ADDR_I == `ACD_OFS_COMMAND);
  assign wr_feat  = HOST_WR_I & (HOST_ADDR_I == `ACD_OFS_FEATURE);
  assign wr_dh    = HOST_WR_I & (HOST_ADDR_I == `ACD_OFS_UNIT_HEAD);
  assign rd_stat  = HOST_RD_I & (HOST_ADDR_I == `ACD_OFS_COMMAND);
  assign rd_alt   = HOST_RD_I & (HOST_ADDR_I == `ACD_OFS_DEV_CTRL);
  assign rd_addr  = HOST_RD_I & (HOST_ADDR_I == `ACD_OFS_UNIT_ADDR);
  // Commands dropped while busy or held in soft reset
  assign cmd_take = wr_cmd & ~BUSY_FLAG_I & ~srst_q;

  // ****************************************************************
  // Device control register
  // ****************************************************************
  logic mask_q;

  // Only soft reset and mask bits kept; busy does not block
  always_ff @(posedge CLOCK_I or negedge rst_b_q)
  begin
    if (!rst_b_q)
    begin
      srst_q <= `ACD_RST_SRST;
      mask_q <= `ACD_RST_MASK;
    end
    else if (wr_ctrl)
    begin
      srst_q <= HOST_WDATA_I[`ACD_CTRL_SRST_BIT];
      mask_q <= HOST_WDATA_I[`ACD_CTRL_MASK_BIT];
    end
  end

  // Soft reset level; configuration state has no soft reset path
  assign SOFT_RESET_O = srst_q;

  // ****************************************************************
  // Parameter shadows
  // ****************************************************************
  logic [7:0] feature_q;
  logic [7:0] unit_head_q;

  // Feature and unit/head copies for decode and readback
  always_ff @(posedge CLOCK_I or negedge rst_b_q)
  begin
    if (!rst_b_q)
    begin
      feature_q   <= `ACD_RST_BYTE;
      unit_head_q <= `ACD_RST_BYTE;
    end
    else
    begin
      if (wr_feat)
        feature_q <= HOST_WDATA_I;
      if (wr_dh)
        unit_head_q <= HOST_WDATA_I;
    end
  end

  // ****************************************************************
  // Interrupt pending
  // ****************************************************************
  logic pend_q;
  logic pend_d;
  logic irq_evt;

  // Event beats a same-cycle status read or soft reset clear
  assign irq_evt = EVT_DONE_I | EVT_DRQ_I;
  assign pend_d  = irq_evt | (pend_q & ~rd_stat & ~srst_q);

  always_ff @(posedge CLOCK_I or negedge rst_b_q)
  begin
    if (!rst_b_q)
      pend_q <= 1'h0;
    else
      pend_q <= pend_d;
  end

  // Mask gates both the pin and the configuration flag
  assign IRQ_O     = pend_q & ~mask_q;
  assign CFG_INT_O = pend_q & ~mask_q;

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic       unit_sel;
  logic       unit_active;
  logic       ds1_low;
  logic       ds0_low;
  logic [7:0] unit_addr;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;

  // Drive address readback fields
  assign unit_sel    = unit_head_q[`ACD_UH_UNIT_BIT];
  assign unit_active = ~srst_q;
  assign ds1_low     = ~(unit_active & unit_sel & UNIT_ID_I);
  assign ds0_low     = ~(unit_active & ~unit_sel & ~UNIT_ID_I);
  assign unit_addr   = {1'h0, ~MEDIA_WRITE_I,
                        ~unit_head_q[3:0],
                        ds1_low, ds0_low};
  // Status and alternate return the status byte, drive address its fields, others zero
  assign rdata_d = (rd_stat | rd_alt) ? STATUS_I :
                   rd_addr            ? unit_addr : `ACD_RST_BYTE;

  always_ff @(posedge CLOCK_I or negedge rst_b_q)
  begin
    if (!rst_b_q)
      rdata_q <= `ACD_RST_BYTE;
    else if (HOST_RD_I)
      rdata_q <= rdata_d;
  end

  assign HOST_RDATA_O = rdata_q;

  // ****************************************************************
  // Command capture
  // ****************************************************************
  logic       dec_known;
  logic [1:0] dec_cls;
  logic [4:0] dec_use;
  acd_uh_t    dec_uh;
  logic       strobe_q;
  logic       abort_q;
  logic [7:0] code_q;
  logic [1:0] cls_q;
  logic [4:0] use_q;
  acd_uh_t    uh_q;
  logic       unit_q;
  logic [3:0] head_q;

  // Decoder on the written code and the loaded feature
  acd_cmd_decode u_dec
  (
    .code_i    (HOST_WDATA_I),
    .feature_i (feature_q),
    .known_o   (dec_known),
    .cls_o     (dec_cls),
    .use_o     (dec_use),
    .uh_o      (dec_uh)
  );

  // Capture of the decoded command; parameters already loaded
  always_ff @(posedge CLOCK_I or negedge rst_b_q)
  begin
    if (!rst_b_q)
    begin
      strobe_q <= 1'h0;
      abort_q  <= 1'h0;
      code_q   <= `ACD_RST_BYTE;
      cls_q    <= `ACD_CLS_NONE;
      use_q    <= 5'h00;
      uh_q     <= UH_NONE;
      unit_q   <= 1'h0;
      head_q   <= 4'h0;
    end
    else
    begin
      strobe_q <= cmd_take & dec_known;
      abort_q  <= cmd_take & ~dec_known;
      if (cmd_take)
      begin
        code_q <= HOST_WDATA_I;
        cls_q  <= dec_cls;
        use_q  <= dec_use;
        uh_q   <= dec_uh;
        unit_q <= unit_sel;
        head_q <= (dec_uh == UH_FULL) ? unit_head_q[3:0] : 4'h0;
      end
    end
  end

  assign CMD_STROBE_O  = strobe_q;
  assign CMD_ABORT_O   = abort_q;
  assign CMD_CODE_O    = code_q;
  assign CMD_CLASS_O   = cls_q;
  assign CMD_USE_O     = use_q;
  assign CMD_UH_MODE_O = uh_q;
  assign CMD_UNIT_O    = unit_q;
  assign CMD_HEAD_O    = head_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!rst_b_q);

  sequence s_cmd(logic [7:0] c);
    wr_cmd && !BUSY_FLAG_I && !srst_q && HOST_WDATA_I == c;
  endsequence

  sequence s_ctrl_wr;
    wr_ctrl;
  endsequence

  ctrl_busy_wr_a: assert property (
    s_ctrl_wr and BUSY_FLAG_I |=> SOFT_RESET_O == $past(HOST_WDATA_I[2]))
    else $error("control write lost while busy");

  srst_hold_a: assert property (
    SOFT_RESET_O && !wr_ctrl |=> SOFT_RESET_O)
    else $error("soft reset dropped without write");

  srst_mask_keep_a: assert property (
    SOFT_RESET_O && !wr_ctrl |=> $stable(mask_q))
    else $error("soft reset disturbed mask");

  irq_masked_a: assert property (
    s_ctrl_wr and HOST_WDATA_I[1] |=> !IRQ_O ##1 (!IRQ_O || $past(wr_ctrl)))
    else $error("interrupt while masked");

  cfg_int_gate_a: assert property (
    mask_q |-> !CFG_INT_O)
    else $error("masked flag reported");

  mask_reset_a: assert property (
    $rose(rst_b_q) |-> !mask_q && !IRQ_O)
    else $error("mask not clear after reset");

  wgate_read_a: assert property (
    rd_addr |=> HOST_RDATA_O[6] == !$past(MEDIA_WRITE_I))
    else $error("write gate readback wrong");

  head_read_a: assert property (
    rd_addr && !wr_dh |=> HOST_RDATA_O[5:2] == ~unit_head_q[3:0])
    else $error("head readback not inverted");

  unit_sel_a: assert property (
    rd_addr && !srst_q && unit_sel == UNIT_ID_I
    |=> HOST_RDATA_O[1:0] != 2'h3)
    else $error("active unit not shown");

  class_two_a: assert property (
    s_cmd(8'h30) |=> CMD_STROBE_O && CMD_CLASS_O == `ACD_CLS_2)
    else $error("single write not class 2");

  class_three_a: assert property (
    s_cmd(8'hCD) |=> CMD_STROBE_O && CMD_CLASS_O == `ACD_CLS_3)
    else $error("multiple write w/o erase not class 3");

  key_change_a: assert property (
    s_cmd(8'hB9) and (feature_q == 8'h81 && !wr_feat)
    |=> CMD_CLASS_O == `ACD_CLS_2)
    else $error("key change not class 2");

  head_drop_a: assert property (
    CMD_STROBE_O && CMD_UH_MODE_O == UH_DRIVE |-> CMD_HEAD_O == 4'h0)
    else $error("head bits kept for drive-only command");

  stat_clear_a: assert property (
    rd_stat && !irq_evt |=> !pend_q)
    else $error("status read left interrupt pending");

  alt_keep_a: assert property (
    rd_alt && pend_q && !srst_q |=> pend_q)
    else $error("alternate read cleared interrupt");

  abort_a: assert property (
    wr_cmd && !BUSY_FLAG_I && !srst_q && !dec_known
    |=> CMD_ABORT_O && !CMD_STROBE_O ##1 (!CMD_ABORT_O || $past(wr_cmd)))
    else $error("unknown code not aborted");

  irq_raise_a: assert property (
    irq_evt && !mask_q && !wr_ctrl |=> IRQ_O)
    else $error("unmasked event gave no interrupt");

endmodule

// >>> inc/acd_pkg.sv
// Types of the task-file control block: unit/head usage and command codes.
// Assumes acd_regs.svh is on the include path.
package acd_pkg;

  // Use of the unit/head register by a command
  typedef enum logic [1:0] {UH_NONE, UH_DRIVE, UH_FULL} acd_uh_t;

  // Command codes
  typedef enum logic [7:0] {
    CMD_NOP = 8'h00, CMD_REQ_SENSE = 8'h03, CMD_READ_A = 8'h20,
    CMD_READ_B = 8'h21, CMD_RDLONG_A = 8'h22, CMD_RDLONG_B = 8'h23,
    CMD_WRITE_A = 8'h30, CMD_WRITE_B = 8'h31, CMD_WRLONG_A = 8'h32,
    CMD_WRLONG_B = 8'h33, CMD_WRITE_NE = 8'h38, CMD_WR_VERIFY = 8'h3C,
    CMD_VERIFY_A = 8'h40, CMD_VERIFY_B = 8'h41, CMD_FORMAT = 8'h50,
    CMD_TRANSLATE = 8'h87, CMD_DIAG = 8'h90, CMD_INIT = 8'h91,
    CMD_STBYIMM_B = 8'h94, CMD_IDLEIMM_B = 8'h95, CMD_STBY_B = 8'h96,
    CMD_IDLE_B = 8'h97, CMD_CHKPWR_B = 8'h98, CMD_SLEEP_B = 8'h99,
    CMD_KEY = 8'hB9, CMD_ERASE = 8'hC0, CMD_RD_MULT = 8'hC4,
    CMD_WR_MULT = 8'hC5, CMD_SET_MULT = 8'hC6, CMD_RD_DMA = 8'hC8,
    CMD_WR_DMA = 8'hCA, CMD_WR_MULT_NE = 8'hCD, CMD_STBYIMM_A = 8'hE0,
    CMD_IDLEIMM_A = 8'hE1, CMD_STBY_A = 8'hE2, CMD_IDLE_A = 8'hE3,
    CMD_RD_BUF = 8'hE4, CMD_CHKPWR_A = 8'hE5, CMD_SLEEP_A = 8'hE6,
    CMD_FLUSH = 8'hE7, CMD_WR_BUF = 8'hE8, CMD_IDENTIFY = 8'hEC,
    CMD_SET_FEAT = 8'hEF, CMD_SEC_SET = 8'hF1, CMD_SEC_UNLOCK = 8'hF2,
    CMD_SEC_PREP = 8'hF3, CMD_SEC_ERASE = 8'hF4, CMD_SEC_FREEZE = 8'hF5,
    CMD_SEC_DIS = 8'hF6
  } acd_cmd_t;

endpackage

// >>> inc/acd_regs.svh
// Offsets, field positions, reset values and codes of the task-file block.
// Included by bare name; definitions only.
//
// Contract
// - Control register writable even while busy
// - Soft reset held until bit cleared
// - Soft reset leaves configuration state untouched
// - Mask bit high suppresses all interrupts
// - Mask also gates configuration status flag
// - Mask bit cleared at reset
// - Only soft reset and mask bits stored
// - Write gate reads low during media write
// - Readback head bits are inverted head select
// - Unit select lows mark active selected unit
// - Commands sorted into three acceptance classes
// - Write without erase codes: classes three, two
// - Key command, feature 0 to 7F: class 1
// - Key feature 80 class 1, 81 class 2
// - Drive-only commands drop head bits
// - Full commands use unit and head bits
// - Status read clears pending, alternate does not
// - Unit select bit picks unit 0 or 1
`ifndef ACD_REGS_SVH
`define ACD_REGS_SVH

`define ACD_OFS_FEATURE   4'h1
`define ACD_OFS_UNIT_HEAD 4'h6
`define ACD_OFS_COMMAND   4'h7
`define ACD_OFS_DEV_CTRL  4'hE
`define ACD_OFS_UNIT_ADDR 4'hF

`define ACD_CTRL_SRST_BIT 2
`define ACD_CTRL_MASK_BIT 1
`define ACD_UH_UNIT_BIT   4
`define ACD_DA_WGATE_BIT  6
`define ACD_DA_DS1_BIT    1
`define ACD_DA_DS0_BIT    0

`define ACD_RST_SRST      1'h0
`define ACD_RST_MASK      1'h0
`define ACD_RST_BYTE      8'h00

`define ACD_KEY_FEAT_MAX  8'h7F
`define ACD_KEY_FEAT_RD   8'h80
`define ACD_KEY_FEAT_CHG  8'h81
`define ACD_CMD_RECAL_HI  4'h1
`define ACD_CMD_SEEK_HI   4'h7

`define ACD_CLS_NONE      2'h0
`define ACD_CLS_1         2'h1
`define ACD_CLS_2         2'h2
`define ACD_CLS_3         2'h3

`endif

// >>> verif/acd_ctrl_tb.sv
// Self-checking bench of the task-file control block.
// Assumes acd_pkg and acd_regs.svh are compiled and on the include path.
`timescale 1ns/1ns
module acd_ctrl_tb;
  import acd_pkg::*;
  logic       clk, rst_b, busy, mwr, unit_id, evt_done, evt_drq, wr, rd;
  logic [3:0] addr, head;
  logic [7:0] wdata, rdata, status, code, v, q, uh;
  logic       srst, irq, cfg_int, stb, abt, unit;
  logic [1:0] cls;
  logic [4:0] use_w;
  acd_uh_t    uhm;
  logic [31:0] seed;
  int         n_mismatch, n_tests;
  // Code, feature, class, unit/head mode (1 drive, 2 full, 0 unknown), use bits
  logic [31:0] tbl [24] = '{32'h2000120F, 32'h3000220F, 32'hC500320F,
    32'hCD00320F, 32'h3800220F, 32'hE5001100, 32'h90001100, 32'h3C00320F,
    32'hE8002100, 32'h13001100, 32'h7A001207, 32'hB900121E, 32'hB97F121E,
    32'hB980121E, 32'hB981221E, 32'hB9820000, 32'hFF000000, 32'hEF001110,
    32'h91001208, 32'h5000220B, 32'h32002207, 32'h22001207, 32'hE3001108,
    32'hC000120F};

  acd_ctrl DUT (.CLOCK_I(clk), .RST_B_I(rst_b), .HOST_ADDR_I(addr),
    .HOST_WR_I(wr), .HOST_RD_I(rd), .HOST_WDATA_I(wdata), .HOST_RDATA_O(rdata),
    .BUSY_FLAG_I(busy), .MEDIA_WRITE_I(mwr), .STATUS_I(status),
    .UNIT_ID_I(unit_id), .EVT_DONE_I(evt_done), .EVT_DRQ_I(evt_drq),
    .SOFT_RESET_O(srst), .IRQ_O(irq), .CFG_INT_O(cfg_int), .CMD_STROBE_O(stb),
    .CMD_ABORT_O(abt), .CMD_CODE_O(code), .CMD_CLASS_O(cls), .CMD_USE_O(use_w),
    .CMD_UH_MODE_O(uhm), .CMD_UNIT_O(unit), .CMD_HEAD_O(head));
  acd_host_model host (.clk_i(clk), .busy_i(busy), .rdata_i(rdata),
    .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));

  // **********************************
  // Helpers
  // **********************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Next random byte
  task automatic rnd(output logic [7:0] r);
    seed = xs(seed);
    r = seed[7:0];
  endtask

  // Compare and count
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One-cycle event pulse
  task automatic pulse(input logic drq);
    @(posedge clk);
    evt_drq  <= drq;
    evt_done <= ~drq;
    @(posedge clk);
    evt_drq  <= 1'b0;
    evt_done <= 1'b0;
    @(negedge clk);
  endtask

  // Drive address readback against the model, s = soft reset active
  task automatic rb(input logic s);
    logic [7:0] d, u, e;
    rnd(d);
    rnd(u);
    @(posedge clk);
    mwr     <= u[0];
    unit_id <= u[1];
    host.acc(1'b1, 4'h6, d, q);
    host.acc(1'b0, 4'hF, 8'h00, q); // bench probe only
    e = {1'b0, ~u[0], ~d[3:0], ~(d[4] & u[1] & ~s), ~(~d[4] & ~u[1] & ~s)};
    chk("drive_addr", q, e);
  endtask

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Watchdog
  initial
  begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    test_done();
  end

  // **********************************
  // Main sequence
  // **********************************
  initial
  begin
    rst_b = 1'b0; busy = 1'b0; mwr = 1'b0; unit_id = 1'b0;
    evt_done = 1'b0; evt_drq = 1'b0; status = 8'h5A; seed = 32'h367B;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("reset_srst", {7'h00, srst}, 8'h00);
    pulse(1'b0);
    chk("reset_irq", {7'h00, irq}, 8'h01);
    host.acc(1'b0, 4'h7, 8'h00, q);
    // Mask on and off, written while busy with random ignored bits
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      busy <= 1'b1;
      rnd(v);
      v[2] = 1'b0;
      v[1] = i[0];
      host.acc(1'b1, 4'hE, v, q);
      pulse(i[0]);
      chk("irq", {7'h00, irq}, {7'h00, ~v[1]});
      chk("cfg_int", {7'h00, cfg_int}, {7'h00, ~v[1]});
      host.acc(1'b0, 4'hE, 8'h00, q);
      chk("alt_keeps", {7'h00, irq}, {7'h00, ~v[1]});
      host.acc(1'b1, 4'hE, v & 8'hFD, q);
      chk("unmask", {7'h00, irq}, 8'h01);
      host.acc(1'b0, 4'h7, 8'h00, q);
      chk("status", q, status);
      chk("status_clr", {7'h00, irq}, 8'h00);
    end
    @(posedge clk);
    busy <= 1'b0;
    for (int i = 0; i < 8; i++)
      rb(1'b0);
    // Decode table
    foreach (tbl[i])
    begin
      rnd(uh);
      host.issue(tbl[i][23:16], uh, tbl[i][31:24]);
      chk("strobe", {7'h00, stb}, {7'h00, tbl[i][11:8] != 4'h0});
      chk("abort", {7'h00, abt}, {7'h00, tbl[i][11:8] == 4'h0});
      chk("class", {6'h00, cls}, {4'h0, tbl[i][15:12]});
      if (tbl[i][11:8] != 4'h0)
      begin
        chk("code", code, tbl[i][31:24]);
        chk("uh_mode", {6'h00, uhm}, {4'h0, tbl[i][11:8]});
        chk("use", {3'h0, use_w}, tbl[i][7:0]);
        chk("unit", {7'h00, unit}, {7'h00, uh[4]});
        chk("head", {4'h0, head}, tbl[i][9] ? {4'h0, uh[3:0]} : 8'h00);
      end
    end
    // Command refused while busy
    @(posedge clk);
    busy <= 1'b1;
    host.acc(1'b1, 4'h7, 8'h20, q);
    chk("busy_drop", {6'h00, stb, abt}, 8'h00);
    @(posedge clk);
    busy <= 1'b0;
    // Soft reset held until cleared
    host.acc(1'b1, 4'hE, 8'h04, q);
    chk("srst_on", {7'h00, srst}, 8'h01);
    host.acc(1'b1, 4'h7, 8'h20, q);
    chk("srst_drop", {6'h00, stb, abt}, 8'h00);
    chk("srst_hold", {7'h00, srst}, 8'h01);
    rb(1'b1);
    host.acc(1'b1, 4'hE, 8'h00, q);
    chk("srst_off", {7'h00, srst}, 8'h00);
    host.issue(8'h00, 8'h10, 8'h30);
    chk("after_srst", {7'h00, stb}, 8'h01);
    // Hardware reset in mid-run clears a set mask and the pending flag
    host.acc(1'b1, 4'hE, 8'h02, q);
    pulse(1'b0);
    chk("masked", {7'h00, irq}, 8'h00);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("rerst_state", {6'h00, irq, srst}, 8'h00);
    pulse(1'b1);
    chk("rerst_unmask", {7'h00, irq}, 8'h01);
    test_done();
  end
endmodule

// >>> verif/acd_host_model.sv
// Host controller model driving the task-file bus of the control block.
// Assumes the bench calls its tasks one at a time, never overlapping.
`timescale 1ns/1ns
module acd_host_model (
  input  wire logic       clk_i,   // Host clock
  input  wire logic       busy_i,  // Device busy flag
  input  wire logic [7:0] rdata_i, // Read data from device
  output logic      [3:0] addr_o,  // Task-file offset
  output logic            wr_o,    // Write strobe
  output logic            rd_o,    // Read strobe
  output logic      [7:0] wdata_o  // Write data
);
  // Idle bus at time zero
  initial
  begin
    addr_o  = 4'h0;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    wdata_o = 8'h00;
  end

  // One access; released address and data show inverted values, strobes return low
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= w;
    rd_o    <= ~w;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    rd_o    <= 1'b0;
    wdata_o <= ~d;
    addr_o  <= ~a;
    @(negedge clk_i);
    q = rdata_i;
  endtask

  // Command issue: parameters first, code last, once not busy or after 100 cycles
  task automatic issue(input logic [7:0] f, input logic [7:0] uh, input logic [7:0] c);
    int n;
    logic [7:0] q;
    n = 0;
    while (busy_i !== 1'b0 && n < 100)
    begin
      @(posedge clk_i);
      n++;
    end
    acc(1'b1, 4'h1, f, q);
    acc(1'b1, 4'h6, uh, q);
    acc(1'b1, 4'h7, c, q);
  endtask
endmodule
